// >>> shared/srcdc_consts.svh
// Timing counts, divider widths and reset values for the synthesizer control.
`ifndef SRCDC_CONSTS_SVH
`define SRCDC_CONSTS_SVH

`define SRCDC_CLK_MHZ          250
`define SRCDC_REF_SETTLE_CYC   65536
`define SRCDC_CAL_CYC          131072
`define SRCDC_RDIV_W           4
`define SRCDC_MDIV_W           14
`define SRCDC_NDIV1_W          8
`define SRCDC_NDIV2_W          10
`define SRCDC_PS_W             3
`define SRCDC_NUM_OUT          8
`define SRCDC_PSA_OUT_MASK     8'h33
`define SRCDC_PSB_OUT_MASK     8'hCC
`define SRCDC_DEF_RDIV         4'h0
`define SRCDC_DEF_MDIV         14'h0000
`define SRCDC_DEF_NDIV1        8'h00
`define SRCDC_DEF_NDIV2        10'h000
`define SRCDC_DEF_PS           3'h0
`define SRCDC_DEF_OUT_EN       8'hFF
`define SRCDC_DEF_SLEW         8'h00
`define SRCDC_DEF_DUAL         8'h00
`define SRCDC_DEF_R3           2'h0
`define SRCDC_DEF_C3           2'h0

`endif

// >>> shared/srcdc_pkg.sv
// Types shared by the synthesizer control block.
package srcdc_pkg;

  typedef enum logic [2:0] {
    SRCDC_ST_RESET,
    SRCDC_ST_SUPPLY,
    SRCDC_ST_SETTLE,
    SRCDC_ST_CAL,
    SRCDC_ST_RUN
  } srcdc_state_t;

endpackage : srcdc_pkg

// >>> design/srcdc_divider.sv
// Continuous divide-by-(setting+1) counter with a one-cycle terminal pulse.
`timescale 1ns/1ps
`default_nettype none

module srcdc_divider #(
  parameter int W = 4
) (
  input  wire logic         clk,
  input  wire logic         reset,
  input  wire logic         hold,
  input  wire logic         tick_in,
  input  wire logic [W-1:0] div_setting,
  output logic              tick_out
);

  typedef struct packed {
    logic [W-1:0] cnt;
    logic         pulse;
  } srcdc_div_st_t;

  srcdc_div_st_t st_r;
  srcdc_div_st_t st_nxt;

  always_comb begin
    st_nxt       = st_r;
    st_nxt.pulse = 1'b0;
    if (hold) begin
      st_nxt.cnt = '0;
    end else if (tick_in) begin
      // Setting of zero divides by one, all ones by two to the width.
      if (st_r.cnt >= div_setting) begin
        st_nxt.cnt   = '0;
        st_nxt.pulse = 1'b1;
      end else begin
        st_nxt.cnt = st_r.cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign tick_out = st_r.pulse;

endmodule : srcdc_divider

`default_nettype wire

// >>> design/srcdc_ctrl.sv
// Reset, calibration sequencing and counter chain of the clock synthesizer.
//
// Summary of operation
// - Run normally only while both power-down and restart pins are high.
// - Either pin low forces reset, held as long as a pin stays low.
// - Pin or power-up reset exit reloads defaults then starts calibration.
// - Soft reset bit high then low recalibrates keeping current settings.
// - Soft reset bit idles low; only its falling pulse triggers reset.
// - After reset, await valid supplies and expired timer, then calibrate.
// - All clock outputs held in reset during oscillator calibration.
// - Reference predivider is 4-bit, divide 1 to 16, before input mux.
// - Input divider after mux is 14-bit, 1 to 16384, feeding detector.
// - Feedback divider is 8-bit stage cascaded with 10-bit stage.
// - First prescaler clocks outputs 0,1,4,5 and feedback; second 2,3,6,7.
// - Single-ended ports drive one or two in-phase signals, slew selectable.
// - Internal third filter pole resistor and capacitor set by settings.
// - Count 64k detector reference cycles before further power-up steps.
// - Oscillator calibration lasts 128k detector reference cycles.
`timescale 1ns/1ps
`default_nettype none

`include "srcdc_consts.svh"

module srcdc_ctrl (
  input  wire logic                      clk,
  input  wire logic                      reset,
  // Device pins, active low; supply_valid is active high.
  input  wire logic                      power_down_pin_n,
  input  wire logic                      hard_restart_pin_n,
  input  wire logic                      supply_valid,
  // Reference side ticks, one cycle per input clock edge.
  input  wire logic                      pri_ref_tick,
  input  wire logic                      sec_ref_tick,
  input  wire logic                      sel_secondary,
  // Oscillator tick, one cycle per oscillator edge.
  input  wire logic                      vco_tick,
  // Configuration, captured on load strobe; soft_reset_bit is sampled every cycle.
  input  wire logic                      cfg_load,
  input  wire logic                      soft_reset_bit,
  input  wire logic [`SRCDC_RDIV_W-1:0]  cfg_rdiv,
  input  wire logic [`SRCDC_MDIV_W-1:0]  cfg_mdiv,
  input  wire logic [`SRCDC_NDIV1_W-1:0] cfg_ndiv1,
  input  wire logic [`SRCDC_NDIV2_W-1:0] cfg_ndiv2,
  input  wire logic [`SRCDC_PS_W-1:0]    cfg_psa,
  input  wire logic [`SRCDC_PS_W-1:0]    cfg_psb,
  input  wire logic [7:0]                cfg_out_en,
  input  wire logic [7:0]                cfg_fast_slew,
  input  wire logic [7:0]                cfg_dual_se,
  input  wire logic [1:0]                cfg_r3_sel,
  input  wire logic [1:0]                cfg_c3_sel,
  // Status and derived controls.
  output logic                           in_reset,
  output logic                           calibrating,
  output logic                           running,
  output logic                           pfd_ref_tick,
  output logic                           pfd_fb_tick,
  output logic                           psa_tick,
  output logic                           psb_tick,
  output logic [7:0]                     out_div_reset,
  output logic [7:0]                     out_enable,
  output logic [7:0]                     out_fast_slew,
  output logic [7:0]                     out_dual_se,
  output logic [1:0]                     lf_r3_sel,
  output logic [1:0]                     lf_c3_sel
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    srcdc_pkg::srcdc_state_t       state;
    logic [17:0]                   cnt;
    logic                          soft_prev;
    logic [`SRCDC_RDIV_W-1:0]      rdiv;
    logic [`SRCDC_MDIV_W-1:0]      mdiv;
    logic [`SRCDC_NDIV1_W-1:0]     ndiv1;
    logic [`SRCDC_NDIV2_W-1:0]     ndiv2;
    logic [`SRCDC_PS_W-1:0]        psa;
    logic [`SRCDC_PS_W-1:0]        psb;
    logic [7:0]                    out_en;
    logic [7:0]                    slew;
    logic [7:0]                    dual;
    logic [1:0]                    r3;
    logic [1:0]                    c3;
  } srcdc_ctrl_st_t;

  srcdc_ctrl_st_t st_r;
  srcdc_ctrl_st_t st_nxt;

  logic pin_reset;
  logic soft_trig;
  logic hold_loop;
  logic rdiv_tick;
  logic mux_tick;
  logic n1_tick;

  assign pin_reset = ~power_down_pin_n | ~hard_restart_pin_n;
  // Trigger on the falling edge so the bit resting low never resets.
  assign soft_trig = st_r.soft_prev & ~soft_reset_bit;
  // Loop counters stay cleared until the settle timer starts.
  assign hold_loop = (st_r.state == srcdc_pkg::SRCDC_ST_RESET) |
                     (st_r.state == srcdc_pkg::SRCDC_ST_SUPPLY);

  function automatic srcdc_ctrl_st_t load_defaults(input srcdc_ctrl_st_t s);
    srcdc_ctrl_st_t d;
    d        = s;
    d.rdiv   = `SRCDC_DEF_RDIV;
    d.mdiv   = `SRCDC_DEF_MDIV;
    d.ndiv1  = `SRCDC_DEF_NDIV1;
    d.ndiv2  = `SRCDC_DEF_NDIV2;
    d.psa    = `SRCDC_DEF_PS;
    d.psb    = `SRCDC_DEF_PS;
    d.out_en = `SRCDC_DEF_OUT_EN;
    d.slew   = `SRCDC_DEF_SLEW;
    d.dual   = `SRCDC_DEF_DUAL;
    d.r3     = `SRCDC_DEF_R3;
    d.c3     = `SRCDC_DEF_C3;
    return d;
  endfunction : load_defaults

  // ----------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------
  always_comb begin
    st_nxt           = st_r;
    st_nxt.soft_prev = soft_reset_bit;
    if (cfg_load) begin
      st_nxt.rdiv   = cfg_rdiv;
      st_nxt.mdiv   = cfg_mdiv;
      st_nxt.ndiv1  = cfg_ndiv1;
      st_nxt.ndiv2  = cfg_ndiv2;
      st_nxt.psa    = cfg_psa;
      st_nxt.psb    = cfg_psb;
      st_nxt.out_en = cfg_out_en;
      st_nxt.slew   = cfg_fast_slew;
      st_nxt.dual   = cfg_dual_se;
      st_nxt.r3     = cfg_r3_sel;
      st_nxt.c3     = cfg_c3_sel;
    end
    if (pin_reset) begin
      // Defaults are reloaded for the whole time a pin is held low.
      st_nxt       = load_defaults(st_nxt);
      st_nxt.state = srcdc_pkg::SRCDC_ST_RESET;
      st_nxt.cnt   = '0;
    end else if (soft_trig) begin
      // Settings stay; only the sequence restarts.
      st_nxt.state = srcdc_pkg::SRCDC_ST_SUPPLY;
      st_nxt.cnt   = '0;
    end else begin
      case (st_r.state)
        srcdc_pkg::SRCDC_ST_RESET: begin
          st_nxt.state = srcdc_pkg::SRCDC_ST_SUPPLY;
        end
        srcdc_pkg::SRCDC_ST_SUPPLY: begin
          if (supply_valid) begin
            st_nxt.state = srcdc_pkg::SRCDC_ST_SETTLE;
          end
          st_nxt.cnt = '0;
        end
        srcdc_pkg::SRCDC_ST_SETTLE: begin
          if (!supply_valid) begin
            st_nxt.state = srcdc_pkg::SRCDC_ST_SUPPLY;
          end else if (pfd_ref_tick) begin
            if (st_r.cnt == 18'(`SRCDC_REF_SETTLE_CYC - 1)) begin
              st_nxt.state = srcdc_pkg::SRCDC_ST_CAL;
              st_nxt.cnt   = '0;
            end else begin
              st_nxt.cnt = st_r.cnt + 18'h0_0001;
            end
          end
        end
        srcdc_pkg::SRCDC_ST_CAL: begin
          if (pfd_ref_tick) begin
            if (st_r.cnt == 18'(`SRCDC_CAL_CYC - 1)) begin
              st_nxt.state = srcdc_pkg::SRCDC_ST_RUN;
              st_nxt.cnt   = '0;
            end else begin
              st_nxt.cnt = st_r.cnt + 18'h0_0001;
            end
          end
        end
        srcdc_pkg::SRCDC_ST_RUN: begin
          st_nxt.cnt = '0;
        end
        default: begin
          st_nxt.state = srcdc_pkg::SRCDC_ST_RESET;
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st_r <= '{state: srcdc_pkg::SRCDC_ST_RESET, cnt: 18'h0_0000,
                soft_prev: 1'b0, rdiv: `SRCDC_DEF_RDIV,
                mdiv: `SRCDC_DEF_MDIV, ndiv1: `SRCDC_DEF_NDIV1,
                ndiv2: `SRCDC_DEF_NDIV2, psa: `SRCDC_DEF_PS,
                psb: `SRCDC_DEF_PS, out_en: `SRCDC_DEF_OUT_EN,
                slew: `SRCDC_DEF_SLEW, dual: `SRCDC_DEF_DUAL,
                r3: `SRCDC_DEF_R3, c3: `SRCDC_DEF_C3};
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Counter chain
  // ----------------------------------------------------------------------
  srcdc_divider #(.W(`SRCDC_RDIV_W)) u_rdiv (
    .clk         (clk),
    .reset       (reset),
    .hold        (hold_loop),
    .tick_in     (pri_ref_tick),
    .div_setting (st_r.rdiv),
    .tick_out    (rdiv_tick)
  );

  // The smart mux follows the predivider; the 20 percent window is the
  // system's job, so no frequency check is made here.
  assign mux_tick = sel_secondary ? sec_ref_tick : rdiv_tick;

  srcdc_divider #(.W(`SRCDC_MDIV_W)) u_mdiv (
    .clk         (clk),
    .reset       (reset),
    .hold        (hold_loop),
    .tick_in     (mux_tick),
    .div_setting (st_r.mdiv),
    .tick_out    (pfd_ref_tick)
  );

  srcdc_divider #(.W(`SRCDC_PS_W)) u_psa (
    .clk         (clk),
    .reset       (reset),
    .hold        (hold_loop),
    .tick_in     (vco_tick),
    .div_setting (st_r.psa),
    .tick_out    (psa_tick)
  );

  srcdc_divider #(.W(`SRCDC_PS_W)) u_psb (
    .clk         (clk),
    .reset       (reset),
    .hold        (hold_loop),
    .tick_in     (vco_tick),
    .div_setting (st_r.psb),
    .tick_out    (psb_tick)
  );

  // First prescaler drives the feedback chain as well.
  srcdc_divider #(.W(`SRCDC_NDIV1_W)) u_ndiv1 (
    .clk         (clk),
    .reset       (reset),
    .hold        (hold_loop),
    .tick_in     (psa_tick),
    .div_setting (st_r.ndiv1),
    .tick_out    (n1_tick)
  );

  srcdc_divider #(.W(`SRCDC_NDIV2_W)) u_ndiv2 (
    .clk         (clk),
    .reset       (reset),
    .hold        (hold_loop),
    .tick_in     (n1_tick),
    .div_setting (st_r.ndiv2),
    .tick_out    (pfd_fb_tick)
  );

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign in_reset    = (st_r.state != srcdc_pkg::SRCDC_ST_RUN);
  assign calibrating = (st_r.state == srcdc_pkg::SRCDC_ST_CAL);
  assign running     = (st_r.state == srcdc_pkg::SRCDC_ST_RUN);
  // Output dividers stay in reset through every step before run.
  assign out_div_reset = {`SRCDC_NUM_OUT{in_reset}};
  assign out_enable    = running ? st_r.out_en : 8'h00;
  assign out_fast_slew = st_r.slew;
  assign out_dual_se   = st_r.dual;
  assign lf_r3_sel     = st_r.r3;
  assign lf_c3_sel     = st_r.c3;

endmodule : srcdc_ctrl

`default_nettype wire

// >>> tb/srcdc_ctrl_props.sv
// Port-level checks for the synthesizer control block.
`timescale 1ns/1ps
`default_nettype none
`include "srcdc_consts.svh"
module srcdc_ctrl_props (
  input wire logic       clk,
  input wire logic       reset,
  input wire logic       power_down_pin_n,
  input wire logic       hard_restart_pin_n,
  input wire logic       supply_valid,
  input wire logic       soft_reset_bit,
  input wire logic       cfg_load,
  input wire logic [7:0] cfg_fast_slew,
  input wire logic [1:0] cfg_r3_sel,
  input wire logic       pfd_ref_tick,
  input wire logic       in_reset,
  input wire logic       calibrating,
  input wire logic       running,
  input wire logic [7:0] out_div_reset,
  input wire logic [7:0] out_enable,
  input wire logic [7:0] out_fast_slew,
  input wire logic [7:0] out_dual_se,
  input wire logic [1:0] lf_r3_sel,
  input wire logic [1:0] lf_c3_sel
);
  // ------
  // Phase tick counters
  // ------
  logic        up;
  logic        settle;
  logic [17:0] set_cnt_r;
  logic [17:0] cal_cnt_r;
  assign up = power_down_pin_n && hard_restart_pin_n;
  // A high soft bit clears the count, because its fall restarts the timer.
  assign settle = in_reset && !calibrating && supply_valid && up &&
                  !soft_reset_bit;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      set_cnt_r <= 18'h0_0000;
      cal_cnt_r <= 18'h0_0000;
    end else begin
      set_cnt_r <= settle ? set_cnt_r + 18'(pfd_ref_tick) : 18'h0_0000;
      cal_cnt_r <= calibrating ? cal_cnt_r + 18'(pfd_ref_tick) : 18'h0_0000;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  a_run_pins_high: assert property (running |-> $past(up))
    else $error("running without both pins high");
  a_pin_forces_reset: assert property (!up |=> in_reset)
    else $error("pin low did not force reset");
  a_pin_loads_defaults: assert property (!up |=>
    out_fast_slew == `SRCDC_DEF_SLEW && out_dual_se == `SRCDC_DEF_DUAL &&
    lf_c3_sel == `SRCDC_DEF_C3) else $error("defaults not reloaded");
  a_soft_starts_recal: assert property ($fell(soft_reset_bit) && up
    |=> in_reset) else $error("soft bit fall did not restart");
  a_soft_keeps_cfg: assert property ($fell(soft_reset_bit) && up &&
    !cfg_load |=> $stable(out_fast_slew) && $stable(lf_r3_sel))
    else $error("soft restart changed settings");
  a_cal_after_settle: assert property ($rose(calibrating) |->
    $past(supply_valid) && set_cnt_r inside {[18'h0_ffff:18'h1_0004]})
    else $error("calibration started at wrong count");
  a_run_after_cal: assert property ($rose(running) |->
    cal_cnt_r inside {[18'h1_ffff:18'h2_0002]})
    else $error("calibration length wrong");
  a_reset_holds_out: assert property (in_reset |->
    out_div_reset == 8'hff && out_enable == 8'h00)
    else $error("outputs not held during reset or calibration");
  a_run_releases_out: assert property (running |->
    out_div_reset == 8'h00) else $error("dividers held while running");
  a_cfg_load_lands: assert property (cfg_load && up |=>
    out_fast_slew == $past(cfg_fast_slew) && lf_r3_sel == $past(cfg_r3_sel))
    else $error("loaded settings not on outputs");
  c_run: cover property ($rose(running));
  c_cal: cover property ($rose(calibrating));
  c_soft: cover property ($fell(soft_reset_bit) && up);
  c_pin: cover property ($fell(hard_restart_pin_n) ##[1:8]
    $rose(hard_restart_pin_n));
endmodule : srcdc_ctrl_props
`default_nettype wire

// >>> tb/srcdc_host.sv
// Host model that drives the reset pins and the soft reset bit.
`timescale 1ns/1ps
`default_nettype none
module srcdc_host (
  input  wire logic clk,
  input  wire logic pd_go,
  input  wire logic rst_go,
  input  wire logic soft_go,
  output logic      power_down_pin_n,
  output logic      hard_restart_pin_n,
  output logic      soft_reset_bit
);
  logic [1:0] soft_cnt_r = 2'h0;
  initial begin
    power_down_pin_n = 1'b1;
    hard_restart_pin_n = 1'b1;
  end
  // The bit rests low, is written high for three cycles, then back low.
  assign soft_reset_bit = (soft_cnt_r != 2'h0);
  always @(posedge clk) begin
    power_down_pin_n <= !pd_go;
    hard_restart_pin_n <= !rst_go;
    if (soft_go) soft_cnt_r <= 2'h3;
    else if (soft_cnt_r != 2'h0) soft_cnt_r <= soft_cnt_r - 2'h1;
  end
endmodule : srcdc_host
`default_nettype wire

// >>> tb/tb_srcdc_ctrl.sv
// Testbench for the synthesizer control block with a host model.
`timescale 1ns/1ps
`default_nettype none
module tb_srcdc_ctrl;
  // ------
  // Stimulus and observed signals
  // ------
  logic        clk = 1'b0, reset = 1'b1, supply_valid = 1'b0;
  logic        pri_ref_tick = 1'b1, sec_ref_tick = 1'b1, vco_tick = 1'b1;
  logic        sel_secondary = 1'b0, cfg_load = 1'b0;
  logic        pd_go = 1'b0, rst_go = 1'b0, soft_go = 1'b0;
  logic [3:0]  cfg_rdiv = 4'h0;
  logic [13:0] cfg_mdiv = 14'h0000;
  logic [7:0]  cfg_ndiv1 = 8'h01;
  logic [9:0]  cfg_ndiv2 = 10'h001;
  logic [2:0]  cfg_psa = 3'h1, cfg_psb = 3'h3;
  logic [7:0]  cfg_out_en = 8'h5a, cfg_fast_slew = 8'ha5, cfg_dual_se = 8'h3c;
  logic [1:0]  cfg_r3_sel = 2'h2, cfg_c3_sel = 2'h1;
  logic        power_down_pin_n, hard_restart_pin_n, soft_reset_bit;
  logic        in_reset, calibrating, running;
  logic        pfd_ref_tick, pfd_fb_tick, psa_tick, psb_tick;
  logic [7:0]  out_div_reset, out_enable, out_fast_slew, out_dual_se;
  logic [1:0]  lf_r3_sel, lf_c3_sel;
  int          error_cnt = 0, checked = 0;
  always #2 clk = ~clk;
  srcdc_host u_srcdc_host (.clk, .pd_go, .rst_go, .soft_go,
    .power_down_pin_n, .hard_restart_pin_n, .soft_reset_bit);
  srcdc_ctrl u_srcdc_ctrl (.clk, .reset, .power_down_pin_n,
    .hard_restart_pin_n, .supply_valid, .pri_ref_tick, .sec_ref_tick,
    .sel_secondary, .vco_tick, .cfg_load, .soft_reset_bit, .cfg_rdiv,
    .cfg_mdiv, .cfg_ndiv1, .cfg_ndiv2, .cfg_psa, .cfg_psb, .cfg_out_en,
    .cfg_fast_slew, .cfg_dual_se, .cfg_r3_sel, .cfg_c3_sel, .in_reset,
    .calibrating, .running, .pfd_ref_tick, .pfd_fb_tick, .psa_tick,
    .psb_tick, .out_div_reset, .out_enable, .out_fast_slew, .out_dual_se,
    .lf_r3_sel, .lf_c3_sel);
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  task automatic chk(input string what, input logic [31:0] seen,
                     input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic close_out();
    if (error_cnt == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : close_out
  task automatic wait_hi(input bit cal, input int lim, output int n);
    n = 0;
    while ((cal ? calibrating : running) !== 1'b1 && n < lim) begin
      cyc(1);
      n++;
    end
    if (n >= lim) begin
      error_cnt++;
      close_out();
    end
  endtask : wait_hi
  task automatic t_powerup();
    int n;
    cyc(10);
    chk("wait supply", {in_reset, calibrating, running}, 3'b100);
    supply_valid = 1'b1;
    cyc(1000);
    supply_valid = 1'b0;
    cyc(5);
    chk("supply drop", {in_reset, calibrating}, 2'b10);
    supply_valid = 1'b1;
    wait_hi(1'b1, 70000, n);
    chk("settle len", n >= 65536 && n <= 65542, 1'b1);
    chk("cal outputs", {out_div_reset, out_enable}, 16'hff00);
    wait_hi(1'b0, 140000, n);
    chk("cal len", n >= 131071 && n <= 131076, 1'b1);
    chk("run outputs", {out_div_reset, out_enable}, 16'h00ff);
  endtask : t_powerup
  task automatic t_meas(input logic sel, input logic [3:0] rd,
                        input int n, input int er);
    int r = 0, f = 0, a = 0, b = 0;
    cfg_rdiv = rd;
    sel_secondary = sel;
    cfg_load = 1'b1;
    cyc(1);
    cfg_load = 1'b0;
    cyc(40);
    repeat (n) begin
      cyc(1);
      r += int'(pfd_ref_tick === 1'b1);
      f += int'(pfd_fb_tick === 1'b1);
      a += int'(psa_tick === 1'b1);
      b += int'(psb_tick === 1'b1);
    end
    chk("ref ticks", r, er);
    chk("fb ticks", f, n / 8);
    chk("psa ticks", a, n / 2);
    chk("psb ticks", b, n / 4);
  endtask : t_meas
  task automatic t_cfg();
    cfg_mdiv = 14'h0001;
    t_meas(1'b0, 4'h3, 80, 10);
    chk("settings", {out_enable, out_fast_slew, out_dual_se, lf_r3_sel,
        lf_c3_sel}, 28'h5aa_53c9);
    t_meas(1'b1, 4'h3, 80, 40);
    t_meas(1'b0, 4'hf, 320, 10);
  endtask : t_cfg
  task automatic t_soft();
    soft_go = 1'b1;
    cyc(1);
    soft_go = 1'b0;
    cyc(2);
    chk("soft high", running, 1'b1);
    cyc(4);
    chk("soft recal", {in_reset, running}, 2'b10);
    chk("soft keeps", {out_fast_slew, lf_r3_sel}, 10'h296);
  endtask : t_soft
  task automatic t_pins();
    for (int i = 0; i < 2; i++) begin
      cfg_load = 1'b1;
      cyc(1);
      cfg_load = 1'b0;
      pd_go = (i == 0);
      rst_go = (i == 1);
      cyc(6);
      chk("pin rst", {in_reset, out_fast_slew, lf_r3_sel}, 11'h400);
      pd_go = 1'b0;
      rst_go = 1'b0;
      cyc(3);
      chk("pin exit", {in_reset, calibrating, running}, 3'b100);
    end
  endtask : t_pins
  initial begin
    cyc(4);
    reset = 1'b0;
    t_powerup();
    t_cfg();
    t_soft();
    t_pins();
    close_out();
  end
endmodule : tb_srcdc_ctrl
bind srcdc_ctrl srcdc_ctrl_props u_srcdc_ctrl_props (.clk, .reset,
  .power_down_pin_n, .hard_restart_pin_n, .supply_valid, .soft_reset_bit,
  .cfg_load, .cfg_fast_slew, .cfg_r3_sel, .pfd_ref_tick, .in_reset,
  .calibrating, .running, .out_div_reset, .out_enable, .out_fast_slew,
  .out_dual_se, .lf_r3_sel, .lf_c3_sel);
`default_nettype wire
